//--- logic/fb_readout.sv
// Feedback readout register: minimum current and periods per dither cycle.
`timescale 1ns/1ps
`default_nettype none
module fb_readout
  import fb_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             cal_mode,
  input  wire logic             feedback_view_select,
  input  wire logic [CH_W-1:0]  chan_sel,
  input  wire logic [NUM_CH-1:0] dither_en,
  input  wire logic [NUM_CH-1:0] chan_operating,
  input  wire meas_t [NUM_CH-1:0] meas,
  input  wire logic             rd_capture,
  output logic [31:0]           rd_data,
  output logic                  rd_valid
);
  // Register state: captured frame word, valid flag, pending clear mask.
  typedef struct packed {
    logic [31:0]       data;
    logic              vld;
    logic [NUM_CH-1:0] clr;
  } rd_t;

  rd_t st_r;
  rd_t st_nxt;
  logic [NUM_CH-1:0][7:0] min_v;
  logic [NUM_CH-1:0][7:0] cnt_v;
  logic [31:0] word;
  logic        ch_ok;

  // Fields are reported only outside calibration, in view one, and for a
  // valid channel number; the same test decides whether a read clears.
  function automatic logic fields_on(input logic            cal,
                                     input logic            view,
                                     input logic [CH_W-1:0] sel);
    fields_on = !cal && view
             && (sel == CH_LOAD_CHANNEL_ZERO || sel == CH_LOAD_CHANNEL_ONE || sel == CH_LOAD_CHANNEL_TWO);
  endfunction : fields_on

  // One tracker per load channel, cleared the cycle after its capture.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    fb_channel u_ch (
      .clk       (clk),
      .resetn    (resetn),
      .meas      (meas[g]),
      .dither_en (dither_en[g]),
      .clr       (st_r.clr[g]),
      .min_out   (min_v[g]),
      .cnt_out   (cnt_v[g])
    );
  end

  // Assemble the live word for the addressed channel.
  always_comb begin
    word  = '0;
    ch_ok = fields_on(cal_mode, feedback_view_select, chan_sel);
    word[CH_LSB +: CH_W] = chan_sel;
    word[RW_BIT] = 1'b0;
    if (ch_ok) begin
      if (chan_operating[chan_sel]) begin
        word[MIN_LSB +: CUR_W] = min_v[chan_sel];
        word[CNT_LSB +: CNT_W] = cnt_v[chan_sel];
      end
    end
  end

  // Capture the frame word first, then clear the channel one cycle later.
  always_comb begin
    st_nxt     = st_r;
    st_nxt.vld = rd_capture;
    st_nxt.clr = '0;
    if (rd_capture) begin
      st_nxt.data = word;
      if (ch_ok) begin
        st_nxt.clr[chan_sel] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{data: REG_RESET, vld: 1'b0, clr: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data  = st_r.data;
  assign rd_valid = st_r.vld;

  // The read marker bit of every returned word is zero.
  AST_RW_ZERO: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_valid |-> rd_data[RW_BIT] == 1'b0)
    else $error("bit 31 read back as one");

  // Bits outside the channel number and the two fields read zero.
  AST_RSVD_ZERO: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_valid |-> rd_data[30:26] == 5'h00 && rd_data[23:16] == 8'h00)
    else $error("unused bits read back nonzero");

  // A channel that is not operating returns both fields as zero.
  AST_IDLE_ZERO: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture && !chan_operating[chan_sel] |=> rd_data[15:0] == 16'h0000)
    else $error("idle channel returned nonzero feedback");

  // Every returned word echoes the channel number it was read for.
  AST_CHAN_ECHO: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture |=> rd_data[25:24] == $past(chan_sel))
    else $error("channel number not echoed");

  // The returned minimum is the value standing before the read clear.
  AST_PRE_RESET: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture && ch_ok && chan_operating[chan_sel]
    |=> rd_data[15:8] == $past(min_v[chan_sel]))
    else $error("captured minimum is not the pre-read value");

  // The returned count is the value standing before the read clear.
  AST_CNT_PRE_RESET: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture && ch_ok && chan_operating[chan_sel]
    |=> rd_data[7:0] == $past(cnt_v[chan_sel]))
    else $error("captured count is not the pre-read value");

  // A read of a dither-off channel returns a zero period count.
  AST_NO_DITHER_FB: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture && ch_ok && !dither_en[chan_sel] |=> rd_data[7:0] == 8'h00)
    else $error("period count returned with dither off");

  // Calibration, view zero or an unused channel number give zero fields.
  AST_QUIET_ZERO: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture && !ch_ok |=> rd_data[15:0] == 16'h0000)
    else $error("fields returned outside view one");

  // Reads in calibration, in view zero or of an unused channel number leave every tracker untouched.
  AST_QUIET_NO_CLR: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture && !ch_ok |=> st_r.clr == '0)
    else $error("tracker cleared by a read outside view one");

  // Only the addressed tracker receives the read clear.
  AST_CLR_PICK: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture && ch_ok |=> st_r.clr == (NUM_CH'(1) << $past(chan_sel)))
    else $error("read clear sent to the wrong tracker");

  // The clear is one cycle long unless a second read follows at once.
  AST_CLR_NEXT: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_capture && ch_ok && chan_sel == CH_LOAD_CHANNEL_ZERO
    |=> st_r.clr[0] ##1 (!st_r.clr[0] || $past(rd_capture)))
    else $error("read clear not a single pulse after capture");

  // The answer flag follows each capture by exactly one cycle.
  AST_VALID_PULSE: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_valid == $past(rd_capture))
    else $error("answer flag not one cycle after capture");

  // The returned word only changes on a capture.
  AST_DATA_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    !$past(rd_capture) |-> $stable(rd_data))
    else $error("returned word changed without a capture");

  // Main scenarios: view one reads, idle channels and back-to-back reads.
  COV_READ_VIEW1: cover property (@(posedge clk)
    rd_capture && feedback_view_select && !cal_mode);
  COV_READ_IDLE: cover property (@(posedge clk)
    rd_capture && !chan_operating[chan_sel]);
  COV_BACK2BACK: cover property (@(posedge clk) rd_capture ##1 rd_capture);
endmodule : fb_readout
`default_nettype wire

//--- include/fb_pkg.sv
// Package with constants and carrier types for the current feedback readout.
package fb_pkg;
  localparam int unsigned NUM_CH     = 3;
  localparam int unsigned CH_W       = 2;
  localparam int unsigned CUR_W      = 8;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned RW_BIT     = 31;
  localparam int unsigned CH_LSB     = 24;
  localparam int unsigned MIN_LSB    = 8;
  localparam int unsigned CNT_LSB    = 0;
  localparam logic [7:0]  MIN_IDLE   = 8'hff;
  localparam logic [7:0]  CNT_IDLE   = 8'h00;
  localparam logic [1:0]  CH_LOAD_CHANNEL_ZERO   = 2'h0;
  localparam logic [1:0]  CH_LOAD_CHANNEL_ONE   = 2'h1;
  localparam logic [1:0]  CH_LOAD_CHANNEL_TWO   = 2'h2;
  localparam logic [31:0] REG_RESET  = 32'h0000ff00;

  // Per-channel measurement inputs from the analog front end.
  typedef struct packed {
    logic       sample_vld;
    logic [7:0] sample;
    logic       period_end;
    logic       dither_end;
  } meas_t;

  // Per-channel tracker state.
  typedef struct packed {
    logic [7:0] run_min;
    logic [7:0] held_min;
    logic [7:0] run_cnt;
    logic [7:0] held_cnt;
  } trk_t;
endpackage : fb_pkg

//--- logic/fb_channel.sv
// One channel's minimum-current and period-count tracker.
`timescale 1ns/1ps
`default_nettype none
module fb_channel
  import fb_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire meas_t meas,
  input  wire logic dither_en,
  input  wire logic clr,
  output logic [7:0] min_out,
  output logic [7:0] cnt_out
);
  trk_t st_r;
  trk_t st_nxt;

  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction : min8

  // Track running values; a read clears first, so a dither cycle that ends
  // on the same edge still hands over its result instead of losing it.
  always_comb begin
    st_nxt = st_r;
    if (meas.sample_vld) begin
      st_nxt.run_min = min8(st_r.run_min, meas.sample);
    end
    if (meas.period_end && st_r.run_cnt != 8'hff) begin
      st_nxt.run_cnt = st_r.run_cnt + 8'h01;
    end
    if (!dither_en) begin
      st_nxt.run_cnt = CNT_IDLE;
    end
    if (clr) begin
      st_nxt.held_min = MIN_IDLE;
      st_nxt.held_cnt = CNT_IDLE;
      if (!dither_en) begin
        st_nxt.run_min = meas.sample_vld ? meas.sample : MIN_IDLE;
      end
    end
    if (dither_en && meas.dither_end) begin
      st_nxt.held_min = st_nxt.run_min;
      st_nxt.held_cnt = st_nxt.run_cnt;
      st_nxt.run_min  = MIN_IDLE;
      st_nxt.run_cnt  = CNT_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{run_min: MIN_IDLE, held_min: MIN_IDLE, run_cnt: CNT_IDLE,
                held_cnt: CNT_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Dither off reports live minimum; on reports the held cycle result.
  assign min_out = dither_en ? st_r.held_min : st_r.run_min;
  assign cnt_out = dither_en ? st_r.held_cnt : CNT_IDLE;

  // A read with no cycle end on the same edge leaves the held minimum idle.
  AST_CLR_MIN: assert property (
    @(posedge clk) disable iff (!resetn)
    clr && !(dither_en && meas.dither_end) |=> st_r.held_min == MIN_IDLE)
    else $error("held minimum not reloaded after read");

  // A read with no cycle end on the same edge clears the held count.
  AST_CLR_CNT: assert property (
    @(posedge clk) disable iff (!resetn)
    clr && !(dither_en && meas.dither_end) |=> st_r.held_cnt == CNT_IDLE)
    else $error("period count not cleared after read");

  // A cycle end that meets a read clear still hands over its minimum.
  AST_SET_WINS: assert property (
    @(posedge clk) disable iff (!resetn)
    clr && dither_en && meas.dither_end && !meas.sample_vld
    |=> st_r.held_min == $past(st_r.run_min))
    else $error("cycle result lost to a coincident read");

  // With dither off the period count always reads zero.
  AST_NO_DITHER_CNT: assert property (
    @(posedge clk) disable iff (!resetn)
    !dither_en |-> cnt_out == CNT_IDLE)
    else $error("period count nonzero with dither off");

  // With dither off the reported minimum only falls until the next read.
  AST_MIN_MONO: assert property (
    @(posedge clk) disable iff (!resetn)
    !dither_en && $past(!dither_en) && !$past(clr)
    |-> min_out <= $past(min_out))
    else $error("running minimum rose without a read");

  COV_DITHER_END: cover property (@(posedge clk) dither_en && meas.dither_end);
  COV_SET_WINS: cover property (@(posedge clk)
    clr && dither_en && meas.dither_end);
endmodule : fb_channel
`default_nettype wire

//--- verif/spi_host.sv
// Host model that issues register reads and collects the words.
`timescale 1ns/1ps
`default_nettype none
module spi_host
  import fb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rd_valid,
  input  wire logic [31:0] rd_data,
  output logic             rd_capture
);
  initial rd_capture = 1'b0;

  // Pulses one capture, then waits a bounded time for the answer.
  task automatic rd(output logic [31:0] w, output bit ok);
    ok = 1'b0;
    w = '0;
    @(posedge clk) rd_capture <= 1'b1;
    @(posedge clk) rd_capture <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) begin
        w = rd_data;
        ok = 1'b1;
      end
    end
  endtask : rd
endmodule : spi_host
`default_nettype wire

//--- verif/min_current_dither_feedback_tb.sv
// Testbench for the feedback readout driven by the host model.
`timescale 1ns/1ps
`default_nettype none
module min_current_dither_feedback_tb;
  import fb_pkg::*;
  logic               clk      = 1'b0;
  logic               resetn   = 1'b0;
  logic               cal      = 1'b0;
  logic               view     = 1'b1;
  logic [CH_W-1:0]    chan_sel = 2'h0;
  logic [NUM_CH-1:0]  dith     = 3'h0;
  logic [NUM_CH-1:0]  oper     = 3'h7;
  meas_t [NUM_CH-1:0] meas     = '0;
  logic               rd_capture;
  logic               rd_valid;
  logic [31:0]        rd_data;
  int                 miscompares = 0;
  int                 cmp_count   = 0;

  always #2.5 clk = ~clk;

  fb_readout u_dut (.clk(clk), .resetn(resetn), .cal_mode(cal),
    .feedback_view_select(view), .chan_sel(chan_sel), .dither_en(dith),
    .chan_operating(oper), .meas(meas), .rd_capture(rd_capture),
    .rd_data(rd_data), .rd_valid(rd_valid));
  spi_host u_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_capture(rd_capture));

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // Reads one word and compares it with the expected fields.
  task automatic read_chk(logic [7:0] mn, logic [7:0] ct);
    logic [31:0] w;
    bit          ok;
    u_host.rd(w, ok);
    cmp_count++;
    if (!ok) begin
      $display("unexpected %0t no answer", $time);
      miscompares++;
      close_out();
    end else if (w !== {6'h0, chan_sel, 8'h00, mn, ct}) begin
      $display("unexpected %0t word %h", $time, w);
      miscompares++;
    end
  endtask : read_chk

  // Pulses one measurement event on a channel.
  task automatic pulse(int ch, meas_t m);
    @(posedge clk) meas[ch] <= m;
    @(posedge clk) meas[ch] <= '0;
  endtask : pulse

  // Dither off: minimum since the last read, count reads zero.
  task automatic dither_off();
    chan_sel <= CH_LOAD_CHANNEL_ZERO;
    pulse(0, meas_t'{1'b1, 8'h40, 1'b0, 1'b0});
    pulse(0, meas_t'{1'b1, 8'h20, 1'b0, 1'b0});
    pulse(0, meas_t'{1'b1, 8'h30, 1'b0, 1'b0});
    read_chk(8'h20, 8'h00);
    read_chk(8'hff, 8'h00);
  endtask : dither_off

  // Dither on: minimum and period count of the completed cycle.
  task automatic dither_on();
    chan_sel <= CH_LOAD_CHANNEL_ONE;
    dith <= 3'h2;
    pulse(1, meas_t'{1'b1, 8'h50, 1'b1, 1'b0});
    pulse(1, meas_t'{1'b1, 8'h10, 1'b1, 1'b0});
    pulse(1, meas_t'{1'b0, 8'h00, 1'b1, 1'b0});
    pulse(1, meas_t'{1'b0, 8'h00, 1'b0, 1'b1});
    read_chk(8'h10, 8'h03);
    read_chk(8'hff, 8'h00);
  endtask : dither_on

  // A channel that is not operating reports zero fields.
  task automatic idle_chan();
    chan_sel <= CH_LOAD_CHANNEL_TWO;
    oper <= 3'h3;
    pulse(2, meas_t'{1'b1, 8'h05, 1'b0, 1'b0});
    read_chk(8'h00, 8'h00);
  endtask : idle_chan

  // Holds reset for ten cycles, checks the idle word, then releases it.
  task automatic reset_chk();
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    cmp_count++;
    if (rd_data !== REG_RESET || rd_valid !== 1'b0) begin
      $display("unexpected %0t reset word %h", $time, rd_data);
      miscompares++;
    end
    resetn <= 1'b1;
    @(posedge clk);
  endtask : reset_chk

  // A read whose clear meets a dither cycle end keeps the new result.
  task automatic read_meets_end();
    pulse(1, meas_t'{1'b1, 8'h33, 1'b1, 1'b0});
    fork
      read_chk(8'hff, 8'h00);
      begin
        @(posedge clk);
        pulse(1, meas_t'{1'b0, 8'h00, 1'b1, 1'b1});
      end
    join
    read_chk(8'h33, 8'h02);
  endtask : read_meets_end

  // Calibration, view zero and an unused channel report no fields and
  // leave the tracker untouched for the next view one read.
  task automatic quiet_views();
    chan_sel <= CH_LOAD_CHANNEL_ZERO;
    pulse(0, meas_t'{1'b1, 8'h60, 1'b0, 1'b0});
    view <= 1'b0;
    read_chk(8'h00, 8'h00);
    view <= 1'b1;
    cal  <= 1'b1;
    read_chk(8'h00, 8'h00);
    cal      <= 1'b0;
    chan_sel <= 2'h3;
    read_chk(8'h00, 8'h00);
    chan_sel <= CH_LOAD_CHANNEL_ZERO;
    read_chk(8'h60, 8'h00);
    read_chk(8'hff, 8'h00);
  endtask : quiet_views

  // A reset in mid-run returns the idle word and empties the trackers.
  task automatic mid_reset();
    pulse(0, meas_t'{1'b1, 8'h08, 1'b0, 1'b0});
    reset_chk();
    read_chk(8'hff, 8'h00);
  endtask : mid_reset

  // Runs reset and then every scenario in turn.
  initial begin
    reset_chk();
    dither_off();
    dither_on();
    read_meets_end();
    idle_chan();
    quiet_views();
    mid_reset();
    close_out();
  end
endmodule : min_current_dither_feedback_tb
`default_nettype wire
